// file: core/sci_pkg.sv
/*
  Constants of the switch configuration host: codes, timing, register map.
  Assumes a 40 MHz system clock.
*/
`default_nettype none

package sci_pkg;

  // ==========================================================================
  // timing
  localparam int unsigned CLK_HZ      = 40_000_000;
  localparam int unsigned SPI_MAX_HZ  = 5_000_000;
  localparam int unsigned I2C_HZ      = 400_000;
  // round up so the bit rate never exceeds the limit
  localparam logic [7:0]  SPI_QTR_CYC = 8'((CLK_HZ + 4 * SPI_MAX_HZ - 1) / (4 * SPI_MAX_HZ));
  localparam logic [7:0]  I2C_QTR_CYC = 8'((CLK_HZ + 4 * I2C_HZ - 1) / (4 * I2C_HZ));

  // ==========================================================================
  // strap codes and protocol bytes
  localparam logic [1:0]  STRAP_EEPROM = 2'h0;
  localparam logic [1:0]  STRAP_I2C    = 2'h1;
  localparam logic [1:0]  STRAP_SPI    = 2'h2;
  localparam logic [7:0]  I2C_ADDR_RD  = 8'hbf;
  localparam logic [7:0]  I2C_ADDR_WR  = 8'hbe;
  localparam logic [7:0]  SPI_CMD_RD   = 8'h03;
  localparam logic [7:0]  SPI_CMD_WR   = 8'h02;
  localparam logic [7:0]  REG_LAST     = 8'h8d;
  localparam logic [7:0]  FABRIC_REG   = 8'h01;
  localparam int unsigned FABRIC_BIT   = 0;

  // ==========================================================================
  // register map
  localparam int unsigned AXI_AW       = 12;
  localparam logic [11:0] OFF_CTRL     = 12'h000;
  localparam logic [11:0] OFF_STATUS   = 12'h004;
  localparam logic [11:0] OFF_PINS     = 12'h008;
  localparam logic [1:0]  BUF_SEL      = 2'h1;
  localparam int unsigned CTRL_GO      = 0;
  localparam int unsigned CTRL_WRITE   = 1;
  localparam int unsigned ST_BUSY      = 0;
  localparam int unsigned ST_DONE      = 1;
  localparam int unsigned ST_NACK      = 2;
  localparam int unsigned ST_REFUSED   = 3;
  localparam int unsigned ST_STARTED   = 4;
  localparam int unsigned PIN_RESET    = 0;
  localparam int unsigned PIN_STRAP    = 1;
  localparam int unsigned PIN_POWER_DOWN_LOW    = 3;
  localparam logic        PIN_RESET_RST = 1'b1;
  localparam logic [1:0]  PIN_STRAP_RST = 2'h2;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  typedef enum logic [2:0] {
    SCI_IDLE  = 3'h0,
    SCI_START = 3'h1,
    SCI_NEXT  = 3'h3,
    SCI_LOAD  = 3'h2,
    SCI_BITS  = 3'h6,
    SCI_STOP  = 3'h7
  } sci_state_e;

  typedef enum logic [1:0] {
    SCI_SEG_CMD   = 2'h0,
    SCI_SEG_ADDR  = 2'h1,
    SCI_SEG_RADDR = 2'h3,
    SCI_SEG_DATA  = 2'h2
  } sci_seg_e;

endpackage : sci_pkg

`default_nettype wire

// file: core/sci_sync2.sv
/*
  Two-flop synchroniser for independent levels.
  Assumes slow levels; bits are not kept coherent with each other.
*/
`default_nettype none

module sci_sync2 #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] din,
  output var  logic [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta <= '0;
      dout <= '0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule // sci_sync2

`default_nettype wire

// file: core/sci_buf.sv
/*
  Byte buffer with two ports, each with a write and a registered read.
  Assumes no same-cycle writes to one address; port b wins if so.
*/
`default_nettype none

module sci_buf #(
  parameter int unsigned DEPTH = 256,
  parameter int unsigned AW    = 8
) (
  input  wire logic          aclk,
  input  wire logic          a_we,
  input  wire logic [AW-1:0] a_wa,
  input  wire logic [7:0]    a_wd,
  input  wire logic [AW-1:0] a_ra,
  output var  logic [7:0]    a_rd,
  input  wire logic          b_we,
  input  wire logic [AW-1:0] b_wa,
  input  wire logic [7:0]    b_wd,
  input  wire logic [AW-1:0] b_ra,
  output var  logic [7:0]    b_rd
);

  logic [7:0] mem [DEPTH];

  always_ff @(posedge aclk) begin
    if (a_we) begin
      mem[a_wa] <= a_wd;
    end
    if (b_we) begin
      mem[b_wa] <= b_wd;
    end
    a_rd <= mem[a_ra];
    b_rd <= mem[b_ra];
  end

endmodule // sci_buf

`default_nettype wire

// file: core/sci_host.sv
/*
  Switch configuration host: AXI4-Lite registers drive an SPI or I2C master.
  Assumes open-drain wires are resolved outside from the output enables.
*/
`default_nettype none

// Contract
// [R1] strap 00 eeprom, 01 i2c, 10 spi
// [R2] eeprom mode loads registers 0 onward
// [R3] loader writes registers 0..120 only
// [R4] bad eeprom signature aborts load
// [R5] eeprom load completes under 15 ms
// [R6] no eeprom means default register values
// [R7] power-down held inactive during chip reset
// [R8] i2c device addresses 0xbf read, 0xbe write
// [R9] i2c registers addressed like small eeprom
// [R10] tables reached through registers 121..131
// [R11] fabric go bit zero after reset
// [R12] fabric go sticks at one until reset
// [R13] configure fully before setting fabric go
// [R14] spi command 0x03 read, 0x02 write
// [R15] select held low continues burst read
// [R16] select held low continues burst write
// [R17] burst address wraps after register 141
// [R18] spi clock no faster than 5 MHz
// [R19] data out on fall, sampled on rise
// [R20] spi frame: command, address, data bytes
// [R21] i2c write phase, repeated start for reads
module sci_host
(
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic [sci_pkg::AXI_AW-1:0] awaddr,
  input  wire logic                      awvalid,
  output var  logic                      awready,
  input  wire logic [31:0]               wdata,
  input  wire logic [3:0]                wstrb,
  input  wire logic                      wvalid,
  output var  logic                      wready,
  output var  logic [1:0]                bresp,
  output var  logic                      bvalid,
  input  wire logic                      bready,
  input  wire logic [sci_pkg::AXI_AW-1:0] araddr,
  input  wire logic                      arvalid,
  output var  logic                      arready,
  output var  logic [31:0]               rdata,
  output var  logic [1:0]                rresp,
  output var  logic                      rvalid,
  input  wire logic                      rready,
  output var  logic [1:0]                config_port_select,
  output var  logic                      chip_reset_low,
  output var  logic                      power_down_low,
  output var  logic                      slave_select_n,
  output var  logic                      spi_clock_pin,
  output var  logic                      spi_data_in_pin,
  input  wire logic                      spi_data_out_pin,
  input  wire logic                      i2c_scl_in,
  output var  logic                      i2c_scl_out,
  output var  logic                      i2c_scl_oe,
  input  wire logic                      i2c_sda_in,
  output var  logic                      i2c_sda_out,
  output var  logic                      i2c_sda_oe
);

  import sci_pkg::*;

  // ==========================================================================
  // pin synchronisers and bit timing
  logic        miso_s;
  logic        scl_s;
  logic        sda_s;
  sci_state_e  state;
  logic        eng_spi;
  logic        tick;
  logic [1:0]  phase;

  sci_sync2 #(.WIDTH(3)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     ({spi_data_out_pin, i2c_scl_in, i2c_sda_in}),
    .dout    ({miso_s, scl_s, sda_s})
  );

  logic tick_run;
  assign tick_run = (state == SCI_START) || (state == SCI_BITS) || (state == SCI_STOP);

  logic [7:0] tick_load;
  assign tick_load = eng_spi ? SPI_QTR_CYC : I2C_QTR_CYC; // R18

  logic tick_q;
  logic [7:0] tick_cnt;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt <= 8'h00;
      tick_q   <= 1'b0;
    end else if (!tick_run || tick_cnt == 8'h00) begin
      tick_cnt <= tick_load - 8'h01;
      tick_q   <= tick_run;
    end else begin
      tick_cnt <= tick_cnt - 8'h01;
      tick_q   <= 1'b0;
    end
  end
  // a target may stretch scl: hold the high phase until scl reads high
  assign tick = tick_q && !(!eng_spi && phase == 2'h3 && !scl_s);

  // ==========================================================================
  // axi write channel
  logic [11:0] aw_q;
  logic [31:0] w_q;
  logic [3:0]  ws_q;
  logic        aw_held;
  logic        w_held;
  logic        wr_fire;
  assign wr_fire = aw_held && w_held && !bvalid;

  logic wr_ctrl;
  logic wr_stat;
  logic wr_pins;
  logic wr_buf;
  assign wr_ctrl = wr_fire && aw_q == OFF_CTRL;
  assign wr_stat = wr_fire && aw_q == OFF_STATUS;
  assign wr_pins = wr_fire && aw_q == OFF_PINS;
  assign wr_buf  = wr_fire && aw_q[11:10] == BUF_SEL && aw_q[1:0] == 2'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready  <= 1'b1;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_q    <= 12'h000;
      w_q     <= 32'h0000_0000;
      ws_q    <= 4'h0;
    end else begin
      if (awvalid && awready) begin
        aw_q    <= awaddr;
        aw_held <= 1'b1;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        w_q    <= wdata;
        ws_q   <= wstrb;
        w_held <= 1'b1;
        wready <= 1'b0;
      end
      if (wr_fire) begin
        bvalid  <= 1'b1;
        bresp   <= (wr_ctrl || wr_stat || wr_pins || wr_buf) ? RESP_OKAY : RESP_SLVERR;
        aw_held <= 1'b0;
        w_held  <= 1'b0;
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // control, pin and status registers
  logic       ctrl_write;
  logic [7:0] ctrl_addr;
  logic [7:0] ctrl_cnt;
  logic       go_q;
  logic       pin_reset;
  logic [1:0] pin_strap;
  logic       pin_pd;
  logic       st_done;
  logic       st_nack;
  logic       st_refused;
  logic       st_started;
  logic       eng_done;
  logic       eng_nack;
  logic       eng_fab;
  logic       busy;
  assign busy = (state != SCI_IDLE) || go_q || eng_done;

  logic go_req;
  logic go_ok;
  assign go_req = wr_ctrl && ws_q[0] && w_q[CTRL_GO];
  // eeprom strap: the device loads itself, there is nothing to drive
  assign go_ok  = !busy && !pin_reset && (ws_q[2] ? w_q[23:16] : ctrl_cnt) != 8'h00 &&
                  (pin_strap == STRAP_SPI || pin_strap == STRAP_I2C);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_write <= 1'b0;
      ctrl_addr  <= 8'h00;
      ctrl_cnt   <= 8'h00;
    end else if (wr_ctrl && !busy) begin
      if (ws_q[0]) ctrl_write <= w_q[CTRL_WRITE];
      if (ws_q[1]) ctrl_addr  <= w_q[15:8];
      if (ws_q[2]) ctrl_cnt   <= w_q[23:16];
    end
  end

  // go acts a cycle late so that fields written with it are used
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      go_q <= 1'b0;
    end else begin
      go_q <= go_req && go_ok;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_reset <= PIN_RESET_RST;
      pin_strap <= PIN_STRAP_RST;
      pin_pd    <= 1'b0;
    end else if (wr_pins && ws_q[0] && !busy) begin
      pin_reset <= w_q[PIN_RESET];
      pin_pd    <= w_q[PIN_POWER_DOWN_LOW];
      // the device samples the strap only in reset
      if (pin_reset || w_q[PIN_RESET]) pin_strap <= w_q[PIN_STRAP +: 2]; // R1
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      config_port_select <= PIN_STRAP_RST;
      chip_reset_low     <= !PIN_RESET_RST;
      power_down_low     <= 1'b1;
    end else begin
      config_port_select <= pin_strap; // R1
      chip_reset_low     <= !pin_reset;
      power_down_low     <= !(pin_pd && !pin_reset); // R7
    end
  end

  // sticky flags: a hardware set beats a same-cycle clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_done    <= 1'b0;
      st_nack    <= 1'b0;
      st_refused <= 1'b0;
      st_started <= 1'b0;
    end else begin
      st_done    <= eng_done || (st_done && !(wr_stat && ws_q[0] && w_q[ST_DONE]));
      st_nack    <= eng_nack || (st_nack && !(wr_stat && ws_q[0] && w_q[ST_NACK]));
      st_refused <= (go_req && !go_ok) ||
                    (st_refused && !(wr_stat && ws_q[0] && w_q[ST_REFUSED]));
      // the device cannot stop again; only its reset clears this
      st_started <= eng_fab || (st_started && !pin_reset); // R12 R13
    end
  end

  // ==========================================================================
  // buffer and axi read channel
  logic [7:0] a_rd;
  logic [7:0] b_rd;
  logic       b_we;
  logic [7:0] b_wa;
  logic [7:0] b_wd;
  logic [7:0] data_idx;

  sci_buf #(.DEPTH(256), .AW(8)) u_buf (
    .aclk (aclk),
    .a_we (wr_buf && ws_q[0] && !busy),
    .a_wa (aw_q[9:2]),
    .a_wd (w_q[7:0]),
    .a_ra (araddr[9:2]),
    .a_rd (a_rd),
    .b_we (b_we),
    .b_wa (b_wa),
    .b_wd (b_wd),
    .b_ra (data_idx),
    .b_rd (b_rd)
  );

  logic [11:0] ar_q;
  logic        rpend;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rpend   <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= RESP_OKAY;
      ar_q    <= 12'h000;
    end else begin
      if (arvalid && arready) begin
        ar_q    <= araddr;
        arready <= 1'b0;
        rpend   <= 1'b1;
      end
      if (rpend) begin
        rpend  <= 1'b0;
        rvalid <= 1'b1;
        rresp  <= RESP_OKAY;
        if (ar_q == OFF_CTRL) begin
          rdata <= {8'h00, ctrl_cnt, ctrl_addr, 6'h00, ctrl_write, 1'b0};
        end else if (ar_q == OFF_STATUS) begin
          rdata <= {27'h0, st_started, st_refused, st_nack, st_done, busy};
        end else if (ar_q == OFF_PINS) begin
          rdata <= {28'h0, pin_pd, pin_strap, pin_reset};
        end else if (ar_q[11:10] == BUF_SEL && ar_q[1:0] == 2'h0) begin
          rdata <= {24'h00_0000, a_rd};
        end else begin
          rdata <= 32'h0000_0000;
          rresp <= RESP_SLVERR;
        end
      end
      if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // serial engine
  sci_seg_e   seg;
  logic       eng_write;
  logic [3:0] bit_cnt;
  logic [7:0] byte_left;
  logic [7:0] dev_addr;
  logic [7:0] tx;
  logic [7:0] tx_hold;
  logic [7:0] rx;

  logic host_rx;
  logic last_byte;
  logic cur_bit;
  logic [3:0] bit_last;
  assign host_rx   = (seg == SCI_SEG_DATA) && !eng_write;
  assign last_byte = byte_left == 8'h01;
  // ninth i2c bit: acknowledge each read byte except the last
  assign cur_bit   = (bit_cnt == 4'h8) ? (!host_rx || last_byte) : tx[7];
  assign bit_last  = eng_spi ? 4'h7 : 4'h8;

  logic [7:0] tx_sel;
  always_comb begin
    unique case (seg)
      SCI_SEG_CMD: begin
        if (eng_spi) tx_sel = eng_write ? SPI_CMD_WR : SPI_CMD_RD; // R14
        else         tx_sel = I2C_ADDR_WR; // R8
      end
      SCI_SEG_ADDR:  tx_sel = ctrl_addr; // R9 R20
      SCI_SEG_RADDR: tx_sel = I2C_ADDR_RD; // R8
      SCI_SEG_DATA:  tx_sel = eng_write ? b_rd : 8'hff;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state           <= SCI_IDLE;
      seg             <= SCI_SEG_CMD;
      eng_spi         <= 1'b1;
      eng_write       <= 1'b0;
      phase           <= 2'h0;
      bit_cnt         <= 4'h0;
      byte_left       <= 8'h00;
      data_idx        <= 8'h00;
      dev_addr        <= 8'h00;
      tx              <= 8'h00;
      tx_hold         <= 8'h00;
      rx              <= 8'h00;
      b_we            <= 1'b0;
      b_wa            <= 8'h00;
      b_wd            <= 8'h00;
      eng_done        <= 1'b0;
      eng_nack        <= 1'b0;
      eng_fab         <= 1'b0;
      slave_select_n  <= 1'b1;
      spi_clock_pin   <= 1'b0;
      spi_data_in_pin <= 1'b0;
      i2c_scl_out     <= 1'b0;
      i2c_scl_oe      <= 1'b0;
      i2c_sda_out     <= 1'b0;
      i2c_sda_oe      <= 1'b0;
    end else begin
      b_we     <= 1'b0;
      eng_done <= 1'b0;
      eng_nack <= 1'b0;
      eng_fab  <= 1'b0;
      unique case (state)
        SCI_IDLE: begin
          if (go_q) begin
            eng_spi   <= pin_strap == STRAP_SPI;
            eng_write <= ctrl_write;
            byte_left <= ctrl_cnt;
            data_idx  <= 8'h00;
            dev_addr  <= ctrl_addr;
            seg       <= SCI_SEG_CMD;
            phase     <= 2'h0;
            if (pin_strap == STRAP_SPI) begin
              slave_select_n <= 1'b0; // R20
              state          <= SCI_NEXT;
            end else begin
              state <= SCI_START;
            end
          end
        end
        SCI_START: begin
          if (tick) begin
            phase <= phase + 2'h1;
            unique case (phase)
              2'h0: i2c_sda_oe <= 1'b0;
              2'h1: i2c_scl_oe <= 1'b0;
              2'h2: i2c_sda_oe <= 1'b1;
              2'h3: begin
                i2c_scl_oe <= 1'b1;
                state      <= SCI_NEXT;
              end
            endcase
          end
        end
        SCI_NEXT: begin
          state <= SCI_LOAD;
        end
        SCI_LOAD: begin
          tx      <= tx_sel;
          tx_hold <= tx_sel;
          bit_cnt <= 4'h0;
          state   <= SCI_BITS;
        end
        SCI_BITS: begin
          if (tick) begin
            phase <= phase + 2'h1;
            unique case (phase)
              2'h0: begin
                if (eng_spi) begin
                  spi_clock_pin   <= 1'b0; // R19
                  spi_data_in_pin <= tx[7];
                end else begin
                  i2c_scl_oe <= 1'b1;
                end
              end
              2'h1: begin
                if (!eng_spi) i2c_sda_oe <= !cur_bit;
              end
              2'h2: begin
                if (eng_spi) begin
                  spi_clock_pin <= 1'b1;
                  rx            <= {rx[6:0], miso_s}; // R19
                end else begin
                  i2c_scl_oe <= 1'b0;
                end
              end
              2'h3: begin
                if (!eng_spi && bit_cnt != 4'h8) rx <= {rx[6:0], sda_s};
                tx <= {tx[6:0], 1'b0};
                if (bit_cnt != bit_last) begin
                  bit_cnt <= bit_cnt + 4'h1;
                end else if (!eng_spi && !host_rx && sda_s) begin
                  eng_nack <= 1'b1;
                  state    <= SCI_STOP;
                end else begin
                  unique case (seg)
                    SCI_SEG_CMD: begin
                      seg   <= SCI_SEG_ADDR;
                      state <= SCI_NEXT;
                    end
                    SCI_SEG_ADDR: begin
                      if (!eng_spi && !eng_write) begin
                        seg   <= SCI_SEG_RADDR; // R21
                        state <= SCI_START;
                      end else begin
                        seg   <= SCI_SEG_DATA;
                        state <= SCI_NEXT;
                      end
                    end
                    SCI_SEG_RADDR: begin
                      seg   <= SCI_SEG_DATA;
                      state <= SCI_NEXT;
                    end
                    SCI_SEG_DATA: begin
                      if (!eng_write) begin
                        b_we <= 1'b1;
                        b_wa <= data_idx;
                        b_wd <= rx;
                      end else if (dev_addr == FABRIC_REG && tx_hold[FABRIC_BIT]) begin
                        eng_fab <= 1'b1; // R13
                      end
                      data_idx  <= data_idx + 8'h01;
                      dev_addr  <= (dev_addr == REG_LAST) ? 8'h00 : dev_addr + 8'h01; // R17
                      byte_left <= byte_left - 8'h01;
                      // select stays low between bytes, so the device keeps counting
                      state     <= last_byte ? SCI_STOP : SCI_NEXT; // R15 R16
                    end
                  endcase
                end
              end
            endcase
          end
        end
        SCI_STOP: begin
          if (tick) begin
            phase <= phase + 2'h1;
            unique case (phase)
              2'h0: begin
                spi_clock_pin <= 1'b0;
                i2c_scl_oe    <= !eng_spi;
              end
              2'h1: i2c_sda_oe <= !eng_spi;
              2'h2: i2c_scl_oe <= 1'b0;
              2'h3: begin
                i2c_sda_oe     <= 1'b0;
                slave_select_n <= 1'b1;
                eng_done       <= 1'b1;
                state          <= SCI_IDLE;
              end
            endcase
          end
        end
        default: state <= SCI_IDLE;
      endcase
    end
  end

endmodule // sci_host

`default_nettype wire

// file: tb/sci_host_properties.sv
/* Checker on sci_host ports: SPI timing, AXI handshakes.
   Assumes it is bound to sci_host. */
`default_nettype none
module sci_host_properties (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] rdata,
  input wire logic        chip_reset_low,
  input wire logic        power_down_low,
  input wire logic        slave_select_n,
  input wire logic        spi_clock_pin,
  input wire logic        spi_data_in_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // checks
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  power_down_low_in_reset_a: assert property (!chip_reset_low |-> power_down_low)
    else $error("power-down in reset");
  mosi_hold_a: assert property ($past(spi_clock_pin) && spi_clock_pin
    |-> $stable(spi_data_in_pin)) else $error("mosi moved, clock high");
  sclk_framed_a: assert property ($changed(spi_clock_pin)
    |-> !(slave_select_n && $past(slave_select_n))) else $error("clock outside frame");
  sclk_high_a: assert property ($rose(spi_clock_pin) |-> spi_clock_pin[*4])
    else $error("clock high phase short");
  sclk_low_a: assert property ($fell(spi_clock_pin) |-> !spi_clock_pin[*4])
    else $error("clock low phase short");
  aw_block_a: assert property (awvalid && awready |=> !awready)
    else $error("second address taken");
  bresp_hold_a: assert property (bvalid && !bready |=> bvalid)
    else $error("write response dropped");
  read_delay_a: assert property (arvalid && arready |-> ##2 rvalid)
    else $error("read answer late");
  rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read answer dropped");
endmodule // sci_host_properties
bind sci_host sci_host_properties sci_host_properties_inst (.aclk(aclk), .aresetn(aresetn),
  .awvalid(awvalid), .awready(awready), .bvalid(bvalid), .bready(bready), .arvalid(arvalid),
  .arready(arready), .rvalid(rvalid), .rready(rready), .rdata(rdata),
  .chip_reset_low(chip_reset_low), .power_down_low(power_down_low),
  .slave_select_n(slave_select_n), .spi_clock_pin(spi_clock_pin),
  .spi_data_in_pin(spi_data_in_pin));
`default_nettype wire

// file: tb/sci_dev_model.sv
/* Switch configuration port model, SPI slave only.
   Assumes the host drives strap, reset and SPI pins. */
`default_nettype none
module sci_dev_model (
  input wire logic       rst_n,
  input wire logic [1:0] strap,
  input wire logic       ss_n,
  input wire logic       sclk,
  input wire logic       mosi,
  output var logic       miso
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] regs [142];
  logic [7:0] sh, cmd, ad, q;
  logic [1:0] mode;
  logic       o = 1'b0;
  int         n;
  initial foreach (regs[i]) regs[i] = 8'(i * 37);
  // a released line shows the inverse, never a stale bit
  assign miso = ss_n ? ~o : o;
  always @(posedge rst_n) mode = strap;
  always @(negedge rst_n) regs[1][0] = 1'b0;
  always @(negedge ss_n) n = 0;
  always @(posedge sclk) if (!ss_n && mode == 2'h2) begin
    sh = {sh[6:0], mosi};
    n++;
    if (n == 8) cmd = sh;
    if (n == 16) ad = sh;
    if (n > 16 && n % 8 == 0) begin
      if (cmd == 8'h02) regs[ad] = ad == 8'h01 ? sh | regs[1] & 8'h01 : sh;
      ad = ad == 8'h8d ? 8'h00 : ad + 8'h01;
    end
    if (n >= 16 && n % 8 == 0) q = regs[ad];
  end
  always @(negedge sclk) if (!ss_n && cmd == 8'h03 && n >= 16) begin
    o = q[7];
    q = {q[6:0], 1'b0};
  end
endmodule // sci_dev_model
`default_nettype wire

// file: tb/test_sci_host.sv
/* Self-checking bench for sci_host, SPI switch model.
   Assumes the checker binds itself; I2C wires only pull up. */
`default_nettype none
module test_sci_host;
  import sci_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, got;
  logic [1:0]  bresp, rresp, gr, strap;
  logic        awready, wready, bvalid, arready, rvalid, rstn, pdn, ss, sck, mosi, miso;
  logic        scl_oe, sda_oe;
  logic [16:0] lf = 17'h16cdb;
  logic [7:0]  m [142], b;
  int          miscompares = 0, checks_done = 0;
  sci_host sci_host_inst (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .config_port_select(strap), .chip_reset_low(rstn), .power_down_low(pdn),
    .slave_select_n(ss), .spi_clock_pin(sck), .spi_data_in_pin(mosi), .spi_data_out_pin(miso),
    .i2c_scl_in(!scl_oe), .i2c_scl_out(), .i2c_scl_oe(scl_oe), .i2c_sda_in(!sda_oe),
    .i2c_sda_out(), .i2c_sda_oe(sda_oe));
  sci_dev_model sci_dev_model_inst (.rst_n(rstn), .strap(strap), .ss_n(ss), .sclk(sck),
    .mosi(mosi), .miso(miso));
  initial forever #12.5 aclk = !aclk;
  function automatic logic [16:0] nx(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction
  task automatic ck(input logic [31:0] g, e);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge aclk);
    {awaddr, wdata} <= {a, d};
    {awvalid, wvalid, bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'h2;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid && !rready) rready <= 1'b1;
    end while (rvalid !== 1'b1 || !rready);
    {gr, got} = {rresp, rdata};
    rready <= 1'b0;
  endtask
  task automatic run(input logic [31:0] c);
    wr(OFF_CTRL, c);
    do rd(OFF_STATUS); while (got[ST_BUSY] !== 1'b0);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ==========
  // sequence
  initial begin
    foreach (m[i]) m[i] = 8'(i * 37);
    m[1][0] = 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    ck(32'({rstn, pdn, strap}), 32'h6);
    rd(OFF_PINS);
    ck(got, 32'h5);
    rd(12'h100);
    wr(12'h100, 32'h0);
    ck(32'({gr, bresp}), 32'({RESP_SLVERR, RESP_SLVERR}));
    wr(OFF_PINS, 32'h4);
    for (int i = 0; i < 6; i++) begin
      lf = nx(lf);
      b = lf[7:0] | 8'(i == 3);
      wr(12'h400 + 12'(4 * i), 32'(b));
      m[(140 + i) % 142] = b;
    end
    run(32'h00068c03);
    ck(32'(got[4:1]), 32'h9);
    wr(12'h400, 32'h0);
    run(32'h00010103);
    m[1] = 8'h01;
    foreach (m[i]) ck(32'(sci_dev_model_inst.regs[i]), 32'(m[i]));
    run(32'h00058b01);
    for (int i = 0; i < 5; i++) begin
      rd(12'h400 + 12'(4 * i));
      ck(got, 32'(m[(139 + i) % 142]));
    end
    wr(OFF_PINS, 32'hb);
    wr(OFF_PINS, 32'ha);
    run(32'h00010001);
    ck(32'({got[ST_NACK], rstn, pdn, strap}), 32'h19);
    stop_test();
  end
  initial begin
    #2000000;
    miscompares++;
    stop_test();
  end
endmodule // test_sci_host
`default_nettype wire
